//--- rtl/gdram_cfg.svh
// Purpose: named constants for the graphics dram command/address port
// Assumes: single 10 MHz clock, synchronous active-low reset
// Notes:   definitions only
`ifndef GDRAM_CFG_SVH
`define GDRAM_CFG_SVH
// ====================================================
// geometry
`define BANK_COUNT        4
`define BANK_BITS         2
`define ROW_BITS          12
`define COL_BITS          9
`define WORDS_PER_BANK    2097152
`define DATA_BITS         32
`define MASK_BITS         4
`define MODE_BITS         12
// ====================================================
// address field positions
`define SCOPE_BIT         8
`define COL_LOW_MSB       7
`define COL_HIGH_BIT      9
// ====================================================
// command codes {cs_n, ras_n, cas_n, we_n}
`define CODE_MODE_SET     4'h0
`define CODE_REFRESH      4'h1
`define CODE_PRECHARGE    4'h2
`define CODE_ACTIVATE     4'h3
`define CODE_WRITE        4'h4
`define CODE_READ         4'h5
`define CODE_NOP          4'h7
// ====================================================
// reset values
`define ROW_RESET         12'h000
`define MODE_RESET        12'h000
`endif

//--- rtl/gdram_decode.sv
// Purpose: command decode from chip-select and strobes
// Assumes: strobe inputs already synchronised and swapped for mirror
// Notes:   purely combinational
`timescale 1ns/1ps
`include "gdram_cfg.svh"
module gdram_decode
   import gdram_pkg::*;
(
   // strobes, active low
   input  wire logic cs_n_in,
   input  wire logic ras_n_in,
   input  wire logic cas_n_in,
   input  wire logic we_n_in,
   // decoded command
   output cmd_t      cmd_out
);
   logic [3:0] code;
   // ====================================================
   // chip-select forms part of the code
   assign code = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
   always_comb begin
      if (cs_n_in) cmd_out = cmd_none;
      else begin
         case (code)
            `CODE_MODE_SET:  cmd_out = cmd_mode_set;
            `CODE_REFRESH:   cmd_out = cmd_refresh;
            `CODE_PRECHARGE: cmd_out = cmd_precharge;
            `CODE_ACTIVATE:  cmd_out = cmd_activate;
            `CODE_WRITE:     cmd_out = cmd_write;
            `CODE_READ:      cmd_out = cmd_read;
            default:         cmd_out = cmd_none;
         endcase
      end
   end
endmodule : gdram_decode

//--- rtl/gdram_pkg.sv
// Purpose: shared types for the graphics dram command/address port
// Assumes: constants come from gdram_cfg.svh
// Notes:   types only
package gdram_pkg;
   // ====================================================
   // decoded command
   typedef enum logic [2:0] {
      cmd_none, cmd_mode_set, cmd_refresh, cmd_precharge,
      cmd_activate, cmd_write, cmd_read
   } cmd_t;
   // ====================================================
   // clock-enable power state
   typedef enum logic [1:0] {
      pwr_active, pwr_precharge_down, pwr_active_down, pwr_self_refresh
   } pwr_t;
endpackage : gdram_pkg

//--- rtl/gdram_port.sv
// Purpose: command, address and control port of a four-bank graphics dram
// Assumes: controller drives pins; pins pass two flops first
// Notes:   one system clock; link clock pair arrives as sampled levels
//
// Functional notes
// - commands sampled at rising true clock only
// - read data on both clock crossings
// - clock enable gates clocks, buffers, drivers
// - cke low: precharge/self or active power-down
// - cke synchronous except self-refresh exit
// - power-down/self-refresh disable other input buffers
// - chip-select high masks every command
// - command from chip-select and three strobes
// - masked write bytes discarded on both edges
// - bank select picks one of four banks
// - scope bit chooses one or all banks
// - 12-bit row; column bits 0-7,9; bit8 auto precharge
// - mode set takes opcode from address
// - four banks of 2097152 32-bit words
// - mirror swaps row-strobe ball to reserved input
`timescale 1ns/1ps
`include "gdram_cfg.svh"
module gdram_port
   import gdram_pkg::*;
#(
   parameter int ROW_W  = `ROW_BITS,
   parameter int DATA_W = `DATA_BITS,
   parameter int MASK_W = `MASK_BITS
) (
   // system clock and reset
   input  wire logic                 mclk_in,
   input  wire logic                 resetn_in,
   // differential link clock, sampled
   input  wire logic                 ck_in,
   input  wire logic                 ck_n_in,
   input  wire logic                 cke_in,
   // command strobes, active low
   input  wire logic                 cs_n_in,
   input  wire logic                 ras_n_in,
   input  wire logic                 cas_n_in,
   input  wire logic                 we_n_in,
   input  wire logic                 mirror_reserved_input_in,
   input  wire logic                 mirror_select_in,
   // address
   input  wire logic [1:0]           bank_select_in,
   input  wire logic [ROW_W-1:0]     addr_in,
   // write data
   input  wire logic [DATA_W-1:0]    wdata_in,
   input  wire logic [MASK_W-1:0]    write_byte_mask_in,
   input  wire logic                 wdata_valid_in,
   // read data from array
   input  wire logic [DATA_W-1:0]    rdata_in,
   input  wire logic                 rdata_valid_in,
   // decoded command outputs
   output cmd_t                      cmd_out,
   output logic [1:0]                bank_out,
   output logic                      all_banks_out,
   output logic [ROW_W-1:0]          row_address_bits_out,
   output logic [`COL_BITS-1:0]      column_address_bits_out,
   output logic                      auto_precharge_out,
   output logic [`MODE_BITS-1:0]     mode_opcode_out,
   // write path
   output logic [DATA_W-1:0]         wdata_out,
   output logic [MASK_W-1:0]         wbyte_en_out,
   // read path
   output logic [DATA_W-1:0]         rdata_out,
   output logic                      rdata_drive_out,
   // status
   output pwr_t                      pwr_state_out,
   output logic [`BANK_COUNT-1:0]    bank_open_out,
   output logic                      buffers_on_out
);
   // ====================================================
   // pin synchronisers
   localparam int SYNC_W = 12 + ROW_W + DATA_W + MASK_W;
   logic [SYNC_W-1:0] pins_raw, pins_s;
   assign pins_raw = {ck_in, ck_n_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in,
                      mirror_reserved_input_in, mirror_select_in, bank_select_in,
                      wdata_valid_in, addr_in, wdata_in, write_byte_mask_in};
   gdram_sync #(.WIDTH(SYNC_W)) u_sync (
      .mclk_in   (mclk_in),
      .resetn_in (resetn_in),
      .async_in  (pins_raw),
      .sync_out  (pins_s)
   );
   logic ck_s, ck_n_s, cke_s, cs_s, ras_s, cas_s, we_s, rsv_s, mir_s, wv_s;
   logic [1:0]        ba_s;
   logic [ROW_W-1:0]  a_s;
   logic [DATA_W-1:0] wd_s;
   logic [MASK_W-1:0] dm_s;
   assign {ck_s, ck_n_s, cke_s, cs_s, ras_s, cas_s, we_s, rsv_s, mir_s, ba_s,
           wv_s, a_s, wd_s, dm_s} = pins_s;

   // ====================================================
   // link clock crossings and edge detect
   // ck_prev resets low, matching the parked link clock, so no false rise follows reset
   logic ck_prev;
   wire  rise_x = ck_s & ~ck_n_s & ~ck_prev;
   wire  fall_x = ~ck_s & ck_n_s & ck_prev;
   wire  any_x  = rise_x | fall_x;

   // ====================================================
   // mirror remap: row strobe moves to the other ball
   // the unused ball is never read, so a floating level there is harmless
   wire  ras_eff = mir_s ? rsv_s : ras_s;

   // ====================================================
   // power state and buffer gating
   pwr_t pwr, next_pwr;
   wire  cmd_buf_on = (pwr == pwr_active);
   wire  ck_buf_on  = (pwr != pwr_self_refresh);
   wire  cmd_edge   = rise_x & cmd_buf_on & cke_s;

   cmd_t cmd_dec;
   gdram_decode u_dec (
      .cs_n_in  (cs_s),
      .ras_n_in (ras_eff),
      .cas_n_in (cas_s),
      .we_n_in  (we_s),
      .cmd_out  (cmd_dec)
   );
   // refresh code seen with cke low requests self-refresh
   wire  is_rfsh_hold = (cmd_dec == cmd_refresh) & ~cs_s;

   logic [`BANK_COUNT-1:0] open_banks;
   wire  any_open    = |open_banks;
   wire  is_pre      = cmd_edge & (cmd_dec == cmd_precharge);
   wire  scope_all   = a_s[`SCOPE_BIT];
   wire  is_act      = cmd_edge & (cmd_dec == cmd_activate);
   wire  is_rfsh     = cmd_edge & (cmd_dec == cmd_refresh);

   // ====================================================
   // power transitions: entry/exit on rising crossing, self exit async
   always_comb begin
      next_pwr = pwr;
      case (pwr)
         pwr_active: begin
            if (rise_x && !cke_s) begin
               if (any_open) next_pwr = pwr_active_down;
               else if (is_rfsh_hold) next_pwr = pwr_self_refresh;
               else next_pwr = pwr_precharge_down;
            end
         end
         pwr_precharge_down, pwr_active_down: begin
            if (rise_x && cke_s) next_pwr = pwr_active;
         end
         pwr_self_refresh: begin
            if (cke_s) next_pwr = pwr_active;
         end
         default: next_pwr = pwr_active;
      endcase
   end

   // ====================================================
   // bank open tracking
   logic [`BANK_COUNT-1:0] next_open;
   always_comb begin
      next_open = open_banks;
      if (is_act) next_open[ba_s] = 1'b1;
      if (is_pre) begin
         if (scope_all) next_open = '0;
         else next_open[ba_s] = 1'b0;
      end
   end

   // ====================================================
   // state registers
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         pwr        <= pwr_active;
         open_banks <= '0;
         ck_prev    <= 1'b0;
      end else begin
         pwr        <= next_pwr;
         open_banks <= next_open;
         ck_prev    <= ck_s;
      end
   end

   // ====================================================
   // registered command and address outputs
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         cmd_out                 <= cmd_none;
         bank_out                <= '0;
         all_banks_out           <= 1'b0;
         row_address_bits_out    <= `ROW_RESET;
         column_address_bits_out <= '0;
         auto_precharge_out      <= 1'b0;
         mode_opcode_out         <= `MODE_RESET;
      end else begin
         cmd_out <= cmd_edge ? cmd_dec : cmd_none;
         if (cmd_edge) begin
            bank_out      <= ba_s;
            all_banks_out <= is_pre & scope_all;
            if (is_act) row_address_bits_out <= a_s;
            if (cmd_dec == cmd_read || cmd_dec == cmd_write) begin
               column_address_bits_out <= {a_s[`COL_HIGH_BIT], a_s[`COL_LOW_MSB:0]};
               auto_precharge_out      <= a_s[`SCOPE_BIT];
            end
            if (cmd_dec == cmd_mode_set) mode_opcode_out <= `MODE_BITS'(a_s);
         end
      end
   end

   // ====================================================
   // write path: mask sampled on both crossings
   // enables last one mclk per beat; the data word is held to save a clear mux
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         wdata_out    <= '0;
         wbyte_en_out <= '0;
      end else if (any_x && wv_s && cke_s && cmd_buf_on) begin
         wdata_out    <= wd_s;
         wbyte_en_out <= ~dm_s;
      end else begin
         wbyte_en_out <= '0;
      end
   end

   // ====================================================
   // read path: drivers on only with cke high
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         rdata_out       <= '0;
         rdata_drive_out <= 1'b0;
      end else begin
         rdata_drive_out <= any_x & rdata_valid_in & cke_s;
         if (any_x && rdata_valid_in && cke_s) rdata_out <= rdata_in;
      end
   end

   // ====================================================
   // status outputs
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         pwr_state_out  <= pwr_active;
         bank_open_out  <= '0;
         buffers_on_out <= 1'b1;
      end else begin
         pwr_state_out  <= next_pwr;
         bank_open_out  <= next_open;
         buffers_on_out <= ck_buf_on & cke_s;
      end
   end

   // ====================================================
   // checks
   a_mask_blocks_cmd: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (rise_x && cs_s) |=> cmd_out == cmd_none) else $error("cmd not masked");
   a_pre_all_close: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (is_pre && scope_all) |=> open_banks == '0) else $error("pre all");
   a_pre_one_bank: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (is_pre && !scope_all) |=> !open_banks[$past(ba_s)]) else $error("pre one");
   a_act_opens: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      is_act |=> open_banks[$past(ba_s)] && row_address_bits_out == $past(a_s)) else $error("act");
   a_active_down: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (pwr == pwr_active && rise_x && !cke_s && any_open) |=> pwr == pwr_active_down)
      else $error("active pd");
   a_self_exit: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (pwr == pwr_self_refresh && cke_s) |=> pwr == pwr_active) else $error("self exit");
   a_no_cmd_down: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (pwr != pwr_active) |=> cmd_out == cmd_none) else $error("cmd in pd");
   a_write_mask: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (any_x && wv_s && cke_s && cmd_buf_on) |=> wbyte_en_out == ~$past(dm_s)) else $error("mask");
   a_col_split: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (cmd_edge && cmd_dec == cmd_read) |=> auto_precharge_out == $past(a_s[`SCOPE_BIT]))
      else $error("ap bit");
   a_read_edges: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      rdata_drive_out |-> $past(any_x)) else $error("read edge");
   c_activate: cover property (@(posedge mclk_in) is_act);
   c_pre_all: cover property (@(posedge mclk_in) is_pre && scope_all);
   c_self_refresh: cover property (@(posedge mclk_in) pwr == pwr_self_refresh);
   c_masked_write: cover property (@(posedge mclk_in) any_x && wv_s && |dm_s);
   c_active_down: cover property (@(posedge mclk_in) pwr == pwr_active_down);
   // ====================================================
   // power entry/exit, gating, mirror and field capture
   a_refresh_awake: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      is_rfsh |=> pwr == pwr_active) else $error("refresh left active state");
   a_pre_down_entry: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (pwr == pwr_active && rise_x && !cke_s && !any_open && !is_rfsh_hold)
      |=> pwr == pwr_precharge_down) else $error("precharge power-down not entered");
   a_self_entry: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (pwr == pwr_active && rise_x && !cke_s && !any_open && is_rfsh_hold)
      |=> pwr == pwr_self_refresh) else $error("self-refresh not entered");
   a_down_exit: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (pwr inside {pwr_precharge_down, pwr_active_down} && rise_x && cke_s)
      |=> pwr == pwr_active) else $error("power-down exit missed");
   a_down_holds: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (pwr inside {pwr_precharge_down, pwr_active_down} && !rise_x)
      |=> pwr == $past(pwr)) else $error("power-down left off a crossing");
   a_no_write_down: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      !cmd_buf_on |=> wbyte_en_out == '0) else $error("write taken while down");
   a_drive_cke: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      rdata_drive_out |-> $past(cke_s)) else $error("read driven with cke low");
   a_mirror_strobe: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (cmd_edge && mir_s && !cs_s && rsv_s && cas_s && we_s) |=> cmd_out == cmd_none)
      else $error("mirror strobe not remapped");
   a_write_column: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (cmd_edge && cmd_dec == cmd_write)
      |=> column_address_bits_out == {$past(a_s[`COL_HIGH_BIT]), $past(a_s[`COL_LOW_MSB:0])})
      else $error("write column");
   a_mode_capture: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (cmd_edge && cmd_dec == cmd_mode_set) |=> mode_opcode_out == $past(a_s))
      else $error("mode opcode");
endmodule : gdram_port

//--- rtl/gdram_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: input may change at any time
// Notes:   first flop feeds only the second
`timescale 1ns/1ps
module gdram_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             mclk_in,
   input  wire logic             resetn_in,
   // data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   // ====================================================
   // two stages, reset to zero
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : gdram_sync

//--- tb/gdram_ctrl_model.sv
// Purpose: memory controller model driving the command, address and mask pins
// Assumes: tasks are called from the bench at a falling system clock edge
// Notes:   one send is a single link clock cycle spread over 13 system clocks
`timescale 1ns/1ps
module gdram_ctrl_model (
   // system clock and strap
   input  wire logic        mclk_in,
   input  wire logic        mirror_select_in,
   // link clock and enable
   output logic             ck_out,
   output logic             ck_n_out,
   output logic             cke_out,
   // command strobes, active low
   output logic             cs_n_out,
   output logic             ras_n_out,
   output logic             cas_n_out,
   output logic             we_n_out,
   output logic             rsv_out,
   // address and write data
   output logic [1:0]       bank_out,
   output logic [11:0]      addr_out,
   output logic [31:0]      wdata_out,
   output logic [3:0]       mask_out,
   output logic             wvalid_out
);
   // ====================================================
   // idle pins: deselected, clock parked low
   initial begin
      {ck_out, ck_n_out, cke_out} = 3'h3;
      {cs_n_out, ras_n_out, cas_n_out, we_n_out, rsv_out} = 5'h1e;
      {bank_out, addr_out, wdata_out, mask_out, wvalid_out} = '0;
   end

   // ====================================================
   // one command over one full link clock; c is {cs,ras,cas,we}
   task automatic send(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] m, input logic k);
      cke_out    = k | (c == 4'h4) | (c == 4'h5);
      cs_n_out   = c[3];
      ras_n_out  = mirror_select_in ? 1'b0 : c[2];
      rsv_out    = mirror_select_in ? c[2] : 1'b0;
      cas_n_out  = c[1];
      we_n_out   = c[0];
      bank_out   = b;
      addr_out   = a;
      wdata_out  = d;
      mask_out   = m;
      wvalid_out = (c == 4'h4);
      repeat (4) @(negedge mclk_in);
      {ck_out, ck_n_out} = 2'b10;
      repeat (4) @(negedge mclk_in);
      {ck_out, ck_n_out} = 2'b01;
      repeat (4) @(negedge mclk_in);
      // released cs_n, cas and we go high; bank, address, data and mask show the inverse so a stale hold is never mistaken for data
      {cs_n_out, cas_n_out, we_n_out} = 3'h7;
      ras_n_out  = ~mirror_select_in;
      rsv_out    = mirror_select_in ? ~c[2] : 1'b0;
      bank_out   = ~b;
      addr_out   = ~a;
      wdata_out  = ~d;
      mask_out   = ~m;
      wvalid_out = 1'b0;
      @(negedge mclk_in);
   endtask : send

   // self-refresh exit: enable rises while the link clock stands still
   task automatic wake;
      cke_out = 1'b1;
   endtask : wake
endmodule : gdram_ctrl_model

//--- tb/graphics_dram_cmd_addr_port_tb.sv
// Purpose: self-checking bench for the graphics dram command/address port
// Assumes: controller model drives pins; bench drives array read data
// Notes:   pulses are captured at the falling edge, where they are settled
`timescale 1ns/1ps
`include "gdram_cfg.svh"
module graphics_dram_cmd_addr_port_tb import gdram_pkg::*;;
   `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
   // ====================================================
   // nets
   logic        mclk, resetn, ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, rsv, msel, wvalid, rvalid;
   logic [1:0]  bank, bank_o;
   logic [11:0] addr, row_o, mode_o;
   logic [31:0] wdata, rdata, wdata_o, rdata_o;
   logic [3:0]  mask, en_o, open_o, exp_open, got_en;
   logic [8:0]  col_o;
   logic        all_o, ap_o, rdrive_o, buf_o;
   cmd_t        cmd_o, got_cmd;
   pwr_t        pwr_o;
   int          num_errors, n_compared, n_cmd, n_wr, n_rd, i, c0;
   logic [3:0]  c;

   gdram_port u_gdram_port (.mclk_in(mclk), .resetn_in(resetn), .ck_in(ck), .ck_n_in(ck_n), .cke_in(cke),
      .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .mirror_reserved_input_in(rsv),
      .mirror_select_in(msel), .bank_select_in(bank), .addr_in(addr), .wdata_in(wdata),
      .write_byte_mask_in(mask), .wdata_valid_in(wvalid), .rdata_in(rdata), .rdata_valid_in(rvalid),
      .cmd_out(cmd_o), .bank_out(bank_o), .all_banks_out(all_o), .row_address_bits_out(row_o),
      .column_address_bits_out(col_o), .auto_precharge_out(ap_o), .mode_opcode_out(mode_o),
      .wdata_out(wdata_o), .wbyte_en_out(en_o), .rdata_out(rdata_o), .rdata_drive_out(rdrive_o),
      .pwr_state_out(pwr_o), .bank_open_out(open_o), .buffers_on_out(buf_o));

   gdram_ctrl_model u_gdram_ctrl_model (.mclk_in(mclk), .mirror_select_in(msel), .ck_out(ck),
      .ck_n_out(ck_n), .cke_out(cke), .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n),
      .we_n_out(we_n), .rsv_out(rsv), .bank_out(bank), .addr_out(addr), .wdata_out(wdata),
      .mask_out(mask), .wvalid_out(wvalid));

   // ====================================================
   // clock, pulse monitor, watchdog
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(negedge mclk) begin
      if (cmd_o !== cmd_none) begin
         n_cmd++;
         got_cmd = cmd_o;
      end
      if (en_o !== 4'h0) begin
         n_wr++;
         got_en = en_o;
      end
      if (rdrive_o === 1'b1) n_rd++;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      test_done();
   end

   // ====================================================
   // expectations and checks
   function automatic cmd_t exp_cmd(input logic [3:0] k);
      case (k)
         4'h0: return cmd_mode_set;
         4'h1: return cmd_refresh;
         4'h2: return cmd_precharge;
         4'h3: return cmd_activate;
         4'h4: return cmd_write;
         4'h5: return cmd_read;
         default: return cmd_none;
      endcase
   endfunction : exp_cmd

   task automatic check_one(input logic [3:0] k, input logic [1:0] b, input logic [11:0] a, input logic [3:0] m);
      int          q0, w0, r0;
      logic        rw;
      logic [31:0] wd;
      q0 = n_cmd;
      w0 = n_wr;
      r0 = n_rd;
      rw = (k[3:1] == 3'h2);
      wd = $urandom;
      rdata = $urandom;
      rvalid = (k == 4'h5);
      u_gdram_ctrl_model.send(k, b, a, wd, m, 1'b1);
      rvalid = 1'b0;
      `CHK(n_cmd - q0, (exp_cmd(k) != cmd_none) ? 1 : 0)
      if (exp_cmd(k) != cmd_none) `CHK(got_cmd, exp_cmd(k))
      if (k == 4'h3) `CHK(row_o, a)
      if (k == 4'h3 || rw || (k == 4'h2 && !a[8])) `CHK(bank_o, b)
      if (rw) `CHK({ap_o, col_o}, {a[8], a[9], a[7:0]})
      if (k == 4'h2) `CHK(all_o, a[8])
      if (k == 4'h0) `CHK(mode_o, a)
      `CHK(n_wr - w0, (k == 4'h4 && m != 4'hf) ? 2 : 0)
      if (k == 4'h4 && m != 4'hf) `CHK(got_en, ~m)
      if (k == 4'h4) `CHK(wdata_o, wd)
      `CHK(n_rd - r0, (k == 4'h5) ? 2 : 0)
      if (k == 4'h5) `CHK(rdata_o, rdata)
      if (k == 4'h3) exp_open[b] = 1'b1;
      if (k == 4'h2) exp_open = a[8] ? 4'h0 : (exp_open & ~(4'h1 << b));
      // auto precharge timing is left open, so resync with a precharge-all
      if (rw && a[8]) check_one(4'h2, 2'h0, 12'h100, 4'h0);
      else `CHK(open_o, exp_open)
   endtask : check_one

   task automatic pw(input logic [3:0] k, input logic e_k, input pwr_t e);
      u_gdram_ctrl_model.send(k, 2'h2, 12'h0, 32'h0, 4'h0, e_k);
      `CHK(pwr_o, e)
      `CHK(buf_o, e == pwr_active)
   endtask : pw

   task automatic test_done;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   // ====================================================
   // main sequence
   initial begin
      {resetn, msel, rvalid, rdata, exp_open} = '0;
      {num_errors, n_compared, n_cmd, n_wr, n_rd} = '0;
      void'($urandom(58));
      repeat (6) @(negedge mclk);
      `CHK({cmd_o, pwr_o, buf_o, open_o}, {cmd_none, pwr_active, 1'b1, 4'h0})
      resetn = 1'b1;
      repeat (4) @(negedge mclk);
      // corners: full and empty masks, single-bank close, deselected write
      check_one(4'h3, 2'h3, 12'hfff, 4'h0);
      check_one(4'h4, 2'h3, 12'h2ff, 4'hf);
      check_one(4'h4, 2'h3, 12'h0ff, 4'h0);
      check_one(4'h2, 2'h3, 12'h000, 4'h0);
      check_one(4'hc, 2'h1, 12'h3a5, 4'h0);
      for (i = 0; i < 60; i++) begin
         if (i == 30) begin
            msel = 1'b1;
            repeat (4) @(negedge mclk);
         end
         c = 4'($urandom_range(0, 9));
         if (c == 4'h6) c = 4'h7;
         if (c > 4'h7) c = {1'b1, 3'($urandom)};
         check_one(c, 2'($urandom), 12'($urandom), 4'($urandom));
      end
      // power states: open row, commands refused while down, self-refresh
      check_one(4'h3, 2'h1, 12'h0a5, 4'h0);
      pw(4'h7, 1'b0, pwr_active_down);
      c0 = n_cmd;
      pw(4'h3, 1'b0, pwr_active_down);
      `CHK(n_cmd - c0, 0)
      `CHK(open_o, exp_open)
      pw(4'h7, 1'b1, pwr_active);
      check_one(4'h2, 2'h0, 12'h100, 4'h0);
      pw(4'h7, 1'b0, pwr_precharge_down);
      pw(4'h7, 1'b1, pwr_active);
      pw(4'h1, 1'b0, pwr_self_refresh);
      u_gdram_ctrl_model.wake();
      for (i = 0; i < 8 && pwr_o !== pwr_active; i++) @(negedge mclk);
      `CHK(pwr_o, pwr_active)
      test_done();
   end
endmodule : graphics_dram_cmd_addr_port_tb
